// [rtl/shs_standby_ctrl.v]
// Standby controller: light sleep, deep sleep, wakeup and settling wait
// Functional notes
// - Halt instruction puts the device into light sleep.
// - Light sleep keeps both oscillators running, gates the CPU clock.
// - Light sleep stops CPU, x4 multiplier, ADC control and multiplier.
// - Light sleep holds port output latches at their prior values.
// - Light sleep on subclock, main stopped: 16-bit timer only in 24-bit mode.
// - In deep sleep, external interrupts act only if maskable and unmasked.
// - Unmasked request ends light sleep; vector if accept enable, else next.
// - Halt exit without vectoring resumes after one to two CPU clocks.
// - Non-maskable request ends light sleep and always vectors.
// - Reset during light sleep restarts from the reset vector.
// - Stop instruction puts the device into deep sleep.
// - Pending unmasked request at halt entry releases sleep at once.
// - Stop with pending request goes light sleep, settles, then resumes.
// - Deep sleep stops main oscillator, CPU, x4 and holds port latches.
// - Deep sleep stops watchdog, keeps key-return detection operable.
// - Deep sleep on main clock stops 16-bit timer, ADC and multiplier.
// - Deep sleep: first 8-bit timer only on subclock or cascade clock.
// - Deep sleep: other 8-bit timers count only on external clock.
// - Deep sleep: watch timer, display, remote receiver only on subclock.
// - Sleep on subclock: serial interfaces only on external clock.
// - Settle select: 000 2^12, 010 2^15, 100 2^17; reset value 04H.
// - Deep sleep exit vectors or continues only after settling elapses.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`include "shs_defs.vh"

module shs_standby_ctrl #(
  parameter CNT_W = 18
) (
  // Clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // CPU instruction events
  input  wire        halt_exec,
  input  wire        stop_exec,
  // Interrupt flags
  input  wire [15:0] irq_request_flag,
  input  wire [15:0] irq_mask_flag,
  input  wire        irq_accept_enable,
  input  wire        nmi_req,
  // Port latch input from CPU
  input  wire [7:0]  port_latch_in,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Clock generator controls
  output reg         cpu_clk_en,
  output reg         main_osc_en,
  output reg         sub_osc_en,
  output reg         x4_mult_en,
  // Wakeup to CPU
  output reg         wake_vector,
  output reg         wake_next,
  // Peripheral run enables
  output reg         adc_run,
  output reg         mult_run,
  output reg         t16_run,
  output reg         t8a_run,
  output reg         t8b_run,
  output reg         t8c_run,
  output reg         wdt_run,
  output reg         keyret_run,
  output reg         wt_run,
  output reg         disp_run,
  output reg         rc_run,
  output reg         ser0_run,
  output reg         ser1_run,
  // Held port latch
  output reg  [7:0]  port_latch_out
);

  // Settle count for a select code
  function [CNT_W-1:0] settle_cnt;
    input [2:0] sel;
    begin
      case (sel)
        `SHS_SETTLE_12: settle_cnt = `SHS_CNT_12;
        `SHS_SETTLE_15: settle_cnt = `SHS_CNT_15;
        default:        settle_cnt = `SHS_CNT_17;
      endcase
    end
  endfunction

  // Settle select codes that software may load
  function settle_code_ok;
    input [2:0] code;
    begin
      settle_code_ok = (code == `SHS_SETTLE_12) ||
                       (code == `SHS_SETTLE_15) ||
                       (code == `SHS_SETTLE_17);
    end
  endfunction

  // Unit gate: runs unless limited, or when allowed anyway
  function gate_on;
    input limited;
    input allow;
    begin
      gate_on = ~limited | allow;
    end
  endfunction

  // Controller state codes
  localparam [2:0] ST_RUN    = `SHS_ST_RUN;
  localparam [2:0] ST_HALT   = `SHS_ST_HALT;
  localparam [2:0] ST_STOP   = `SHS_ST_STOP;
  localparam [2:0] ST_SETTLE = `SHS_ST_SETTLE;
  localparam [2:0] ST_RESUME = `SHS_ST_RESUME;
  // One count step, sized to the settle counter
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // State, counters and pending wake kind
  reg [2:0]       state_q, state_d;
  reg [2:0]       settle_sel_q;
  reg [11:0]      cfg_q;
  reg [CNT_W-1:0] cnt_q, cnt_d;
  reg [1:0]       wait_q, wait_d;
  reg             pend_vec_q, pend_vec_d;
  reg             wake_vec_d, wake_next_d;

  // Unmasked maskable request present
  wire unmasked  = |(irq_request_flag & ~irq_mask_flag);
  // Next-state decodes shared by the enable processes
  wire run_next  = (state_d == ST_RUN);
  wire stop_next = (state_d == ST_STOP);
  // CPU clocking arrangement from the configuration
  wire subclk    = cfg_q[`SHS_CFG_SUBCLK];
  wire mainstop  = cfg_q[`SHS_CFG_MAINSTOP];
  // Subsystem clock only, main oscillator stopped
  wire sub_only  = subclk & mainstop;

  // Register writes; prohibited select codes are ignored
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      settle_sel_q <= `SHS_SETTLE_RESET;
      cfg_q        <= `SHS_CFG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `SHS_ADDR_SETTLE &&
          settle_code_ok(reg_wdata[2:0]))
        settle_sel_q <= reg_wdata[2:0];
      if (reg_addr == `SHS_ADDR_PERIPH)
        cfg_q <= reg_wdata[11:0];
    end
  end

  // Register reads, data one cycle later
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SHS_ADDR_SETTLE: reg_rdata <= {13'h0000, settle_sel_q};
        `SHS_ADDR_PERIPH: reg_rdata <= {4'h0, cfg_q};
        `SHS_ADDR_STATUS: reg_rdata <= {13'h0000, state_q};
        default:          reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Sleep state machine
  always @* begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    wait_d      = wait_q;
    pend_vec_d  = pend_vec_q;
    wake_vec_d  = 1'b0;
    wake_next_d = 1'b0;
    case (state_q)
      ST_RUN: begin
        // Stop wins when both instructions are flagged together
        if (stop_exec) begin
          if (unmasked) begin
            // Pending request turns stop into halt plus settle
            state_d    = ST_SETTLE;
            cnt_d      = settle_cnt(settle_sel_q);
            pend_vec_d = irq_accept_enable;
          end else begin
            state_d = ST_STOP;
          end
        end else if (halt_exec) begin
          if (unmasked || nmi_req) begin
            // Released as soon as set; CPU keeps its clock
            wake_vec_d  = irq_accept_enable | nmi_req;
            wake_next_d = ~(irq_accept_enable | nmi_req);
          end else begin
            state_d = ST_HALT;
          end
        end
      end
      ST_HALT: begin
        // Non-maskable request first, then unmasked maskable ones
        if (nmi_req) begin
          state_d    = ST_RUN;
          wake_vec_d = 1'b1;
        end else if (unmasked) begin
          if (irq_accept_enable) begin
            state_d    = ST_RUN;
            wake_vec_d = 1'b1;
          end else begin
            // Continue at next instruction after a short wait
            state_d = ST_RESUME;
            wait_d  = `SHS_RESUME_WAIT;
          end
        end
        // Masked requests leave the device asleep
      end
      ST_STOP: begin
        // Only an unmasked maskable request ends deep sleep
        if (unmasked) begin
          state_d    = ST_SETTLE;
          cnt_d      = settle_cnt(settle_sel_q);
          pend_vec_d = irq_accept_enable;
        end
      end
      ST_SETTLE: begin
        // Count main clock cycles with CPU clock gated
        if (cnt_q <= CNT_ONE) begin
          state_d     = ST_RUN;
          wake_vec_d  = pend_vec_q;
          wake_next_d = ~pend_vec_q;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      ST_RESUME: begin
        // Short resume wait, then continue without vectoring
        if (wait_q == 2'h0) begin
          state_d     = ST_RUN;
          wake_next_d = 1'b1;
        end else begin
          wait_d = wait_q - 2'h1;
        end
      end
      default: begin
        // Unused codes fall back to running
        state_d = ST_RUN;
      end
    endcase
  end

  // State registers; reset restarts like ordinary reset
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= ST_RUN;
      cnt_q       <= {CNT_W{1'b0}};
      wait_q      <= 2'h0;
      pend_vec_q  <= 1'b0;
      wake_vector <= 1'b0;
      wake_next   <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      wait_q      <= wait_d;
      pend_vec_q  <= pend_vec_d;
      wake_vector <= wake_vec_d;
      wake_next   <= wake_next_d;
    end
  end

  // Oscillator and CPU clock enables from next state
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cpu_clk_en  <= 1'b1;
      main_osc_en <= 1'b1;
      sub_osc_en  <= 1'b1;
      x4_mult_en  <= 1'b1;
    end else begin
      // CPU clock gated in every sleep and wait state
      cpu_clk_en  <= run_next;
      // Main oscillator stops only in deep sleep
      main_osc_en <= ~stop_next;
      // Subsystem oscillator is never stopped here
      sub_osc_en  <= 1'b1;
      x4_mult_en  <= run_next;
    end
  end

  // ADC and multiplier run only while the CPU does; watchdog per state, key-return always on
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      adc_run    <= 1'b1;
      mult_run   <= 1'b1;
      wdt_run    <= 1'b1;
      keyret_run <= 1'b1;
    end else begin
      adc_run    <= run_next;
      mult_run   <= run_next;
      // Watchdog stops in deep sleep and on the subclock in halt
      if (stop_next)
        wdt_run  <= 1'b0;
      else if (run_next || state_d == ST_RESUME)
        wdt_run  <= 1'b1;
      else
        wdt_run  <= ~subclk;
      // Key-return detection stays live to wake the device
      keyret_run <= 1'b1;
    end
  end

  // Timers, display, receiver and serial units per mode
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      t16_run  <= 1'b1;
      t8a_run  <= 1'b1;
      t8b_run  <= 1'b1;
      t8c_run  <= 1'b1;
      wt_run   <= 1'b1;
      disp_run <= 1'b1;
      rc_run   <= 1'b1;
      ser0_run <= 1'b1;
      ser1_run <= 1'b1;
    end else begin
      case (state_d)
        ST_RUN, ST_RESUME: begin
          // Everything runs while the CPU runs and during the resume wait
          t16_run  <= 1'b1;
          t8a_run  <= 1'b1;
          t8b_run  <= 1'b1;
          t8c_run  <= 1'b1;
          wt_run   <= 1'b1;
          disp_run <= 1'b1;
          rc_run   <= 1'b1;
          ser0_run <= 1'b1;
          ser1_run <= 1'b1;
        end
        ST_STOP: begin
          t16_run  <= 1'b0;
          // First timer on subclock or cascade input
          t8a_run  <= cfg_q[`SHS_CFG_T8A_SUB] |
                      cfg_q[`SHS_CFG_T8A_CASC];
          // Other timers on external clock only
          t8b_run  <= cfg_q[`SHS_CFG_T8B_EXT];
          t8c_run  <= cfg_q[`SHS_CFG_T8C_EXT];
          // Subclock-fed units keep going
          wt_run   <= cfg_q[`SHS_CFG_WT_SUB];
          disp_run <= cfg_q[`SHS_CFG_DISP_SUB];
          rc_run   <= cfg_q[`SHS_CFG_RC_SUB];
          // Serial units need an external clock
          ser0_run <= cfg_q[`SHS_CFG_SER0_EXT];
          ser1_run <= cfg_q[`SHS_CFG_SER1_EXT];
        end
        default: begin
          // Light sleep and settling wait
          t16_run  <= gate_on(sub_only, cfg_q[`SHS_CFG_T16_24B]);
          t8a_run  <= 1'b1;
          t8b_run  <= 1'b1;
          // Third timer needs its external clock on subclock only
          t8c_run  <= gate_on(sub_only, cfg_q[`SHS_CFG_T8C_EXT]);
          wt_run   <= 1'b1;
          disp_run <= 1'b1;
          rc_run   <= 1'b1;
          ser0_run <= gate_on(subclk, cfg_q[`SHS_CFG_SER0_EXT]);
          ser1_run <= gate_on(subclk, cfg_q[`SHS_CFG_SER1_EXT]);
        end
      endcase
    end
  end

  // Port latch tracks the CPU only while it keeps running
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port_latch_out <= 8'h00;
    end else if (state_q == ST_RUN && run_next) begin
      port_latch_out <= port_latch_in;
    end else begin
      // Hold the value from before sleep
      port_latch_out <= port_latch_out;
    end
  end

endmodule

// [rtl/shs_defs.vh]
// Constants for the standby halt/stop controller
`ifndef SHS_DEFS_VH
`define SHS_DEFS_VH
// Settle select codes
`define SHS_SETTLE_12      3'h0
`define SHS_SETTLE_15      3'h2
`define SHS_SETTLE_17      3'h4
`define SHS_SETTLE_RESET   3'h4
// Settle counts in main clock cycles
`define SHS_CNT_12         18'h0_1000
`define SHS_CNT_15         18'h0_8000
`define SHS_CNT_17         18'h2_0000
// Register map
`define SHS_ADDR_SETTLE    4'h0
`define SHS_ADDR_PERIPH    4'h1
`define SHS_ADDR_STATUS    4'h2
// Peripheral configuration field positions
`define SHS_CFG_SUBCLK     0
`define SHS_CFG_MAINSTOP   1
`define SHS_CFG_T16_24B    2
`define SHS_CFG_T8A_SUB    3
`define SHS_CFG_T8A_CASC   4
`define SHS_CFG_T8B_EXT    5
`define SHS_CFG_T8C_EXT    6
`define SHS_CFG_WT_SUB     7
`define SHS_CFG_DISP_SUB   8
`define SHS_CFG_RC_SUB     9
`define SHS_CFG_SER0_EXT   10
`define SHS_CFG_SER1_EXT   11
`define SHS_CFG_RESET      12'h000
// Resume wait after halt release without vectoring
`define SHS_RESUME_WAIT    2'h1
// Controller states
`define SHS_ST_RUN         3'h0
`define SHS_ST_HALT        3'h1
`define SHS_ST_STOP        3'h2
`define SHS_ST_SETTLE      3'h3
`define SHS_ST_RESUME      3'h4
`endif

// [dv/shs_standby_ctrl_props.sv]
// Checker bound to the standby controller ports
`timescale 1ns/10ps
module shs_props (
  // Clock and reset
  input logic        clock, reset_n,
  // CPU and interrupt requests
  input logic        halt_exec, stop_exec, nmi_req, irq_accept_enable,
  input logic [15:0] irq_request_flag, irq_mask_flag,
  // Clock and peripheral enables
  input logic        cpu_clk_en, main_osc_en, sub_osc_en, x4_mult_en,
  input logic        wake_vector, wake_next, adc_run, mult_run,
  input logic        wdt_run, keyret_run,
  input logic [7:0]  port_latch_out
);
  // Some unmasked request is pending
  wire pend = |(irq_request_flag & ~irq_mask_flag);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_halt;
    halt_exec && !stop_exec && !pend && !nmi_req && cpu_clk_en
      |-> ##[1:2] !cpu_clk_en;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt did not gate the cpu clock");
  property p_stop;
    stop_exec && !pend && cpu_clk_en |-> ##[1:2] !main_osc_en;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not halt the main oscillator");
  property p_gate;
    !cpu_clk_en |-> sub_osc_en && !x4_mult_en && !adc_run && !mult_run;
  endproperty
  a_gate: assert property (p_gate)
    else $error("unit running while cpu clock gated");
  property p_deep;
    !main_osc_en |-> !cpu_clk_en && !wdt_run && keyret_run;
  endproperty
  a_deep: assert property (p_deep)
    else $error("deep sleep enables wrong");
  property p_hold;
    !cpu_clk_en [*3] |-> $stable(port_latch_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("port latch moved while asleep");
  property p_pend;
    halt_exec && !stop_exec && pend && irq_accept_enable && cpu_clk_en
      |=> wake_vector;
  endproperty
  a_pend: assert property (p_pend)
    else $error("pending request did not release at once");
  property p_pulse;
    wake_vector || wake_next |=> !(wake_vector || wake_next);
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("wake pulse longer than one cycle");
  property p_one;
    !(wake_vector && wake_next);
  endproperty
  a_one: assert property (p_one)
    else $error("both wake kinds at once");
endmodule

bind shs_standby_ctrl shs_props shs_props_inst (.clock, .reset_n,
  .halt_exec, .stop_exec, .nmi_req, .irq_accept_enable, .irq_request_flag,
  .irq_mask_flag, .cpu_clk_en, .main_osc_en, .sub_osc_en, .x4_mult_en,
  .wake_vector, .wake_next, .adc_run, .mult_run, .wdt_run, .keyret_run,
  .port_latch_out);

// [dv/shs_irq_model.sv]
// Interrupt flag source and CPU port latch traffic
`timescale 1ns/10ps
module shs_irq_model (
  // Clock and reset
  input  logic        clock, reset_n,
  // Raise, clear and vectored acknowledge
  input  logic [15:0] set_req,
  input  logic        clr_req, ack,
  // Toward the controller
  output logic [15:0] irq_request_flag,
  output logic [7:0]  port_latch_in
);
  // Flags stay set until serviced; latches change every cycle
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_request_flag <= 16'h0000;
      port_latch_in <= 8'h00;
    end else begin
      irq_request_flag <= (ack || clr_req) ? set_req
                                           : irq_request_flag | set_req;
      port_latch_in <= port_latch_in + 8'h01;
    end
  end
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the standby controller
`timescale 1ns/10ps
`include "shs_defs.vh"
module tb_top;
  logic        clock, reset_n, halt_exec, stop_exec, nmi_req, vec, ie;
  logic        irq_accept_enable, reg_wr, reg_rd, clr_req;
  logic [15:0] irq_mask_flag, reg_wdata, set_req, rv;
  logic [3:0]  reg_addr;
  logic [11:0] cfg;
  wire  [15:0] irq_request_flag, reg_rdata;
  wire  [7:0]  port_latch_in, port_latch_out;
  wire cpu_clk_en, main_osc_en, sub_osc_en, x4_mult_en, wake_vector,
    wake_next, adc_run, mult_run, t16_run, t8a_run, t8b_run, t8c_run,
    wdt_run, keyret_run, wt_run, disp_run, rc_run, ser0_run, ser1_run;
  int fail_count = 0, n_compared = 0, cycles = 0, n, t = 0, i, seed;
  shs_standby_ctrl shs_standby_ctrl_inst (.clock, .reset_n, .halt_exec,
    .stop_exec, .irq_request_flag, .irq_mask_flag, .irq_accept_enable,
    .nmi_req, .port_latch_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cpu_clk_en, .main_osc_en, .sub_osc_en, .x4_mult_en,
    .wake_vector, .wake_next, .adc_run, .mult_run, .t16_run, .t8a_run,
    .t8b_run, .t8c_run, .wdt_run, .keyret_run, .wt_run, .disp_run,
    .rc_run, .ser0_run, .ser1_run, .port_latch_out);
  shs_irq_model shs_irq_model_inst (.clock, .reset_n, .set_req, .clr_req,
    .ack(wake_vector), .irq_request_flag, .port_latch_in);
  // 100 ns clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      fail_count++;
      results;
    end
  end
  task chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    rv = reg_rdata;
  endtask
  // Raise sources; zero clears all flags
  task raise(input logic [15:0] s);
    set_req <= s;
    clr_req <= (s == 16'h0000);
    @(posedge clock);
    set_req <= 16'h0000;
    clr_req <= 1'b0;
  endtask
  task sleep(input logic stp, input int w);
    halt_exec <= !stp;
    stop_exec <= stp;
    @(posedge clock);
    halt_exec <= 1'b0;
    stop_exec <= 1'b0;
    repeat (w) @(posedge clock);
  endtask
  task wake;
    n = 0;
    while (wake_vector !== 1'b1 && wake_next !== 1'b1 && n < 40000) begin
      @(posedge clock);
      n++;
    end
    vec = wake_vector;
    nmi_req <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task done;
    t++;
    $display("test %0d done", t);
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Order {t8a, t8b, t8c, wt, disp, rc, ser0, ser1, t16}
  function logic [8:0] exp_stop(input logic [11:0] c);
    return {c[3] | c[4], c[5], c[6], c[7], c[8], c[9], c[10], c[11], 1'b0};
  endfunction
  // Order {t16, ser0, ser1}
  function logic [2:0] exp_halt(input logic [11:0] c);
    return {~(c[0] & c[1]) | c[2], ~c[0] | c[10], ~c[0] | c[11]};
  endfunction
  // Main sequence
  initial begin
    {reset_n, halt_exec, stop_exec, nmi_req, reg_wr, reg_rd, clr_req} = 0;
    irq_accept_enable = 1'b1;
    {irq_mask_flag, reg_wdata, set_req, reg_addr} = 0;
    seed = $urandom(93);
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(`SHS_ADDR_SETTLE);
    chk(rv, 16'h0004);
    wr(`SHS_ADDR_SETTLE, 16'h0003);
    rd(`SHS_ADDR_SETTLE);
    chk(rv, 16'h0004);
    wr(`SHS_ADDR_SETTLE, 16'h0000);
    rd(`SHS_ADDR_SETTLE);
    chk(rv, 16'h0000);
    done;
    irq_mask_flag <= 16'h0001;
    sleep(0, 3);
    raise(16'h0001);
    repeat (20) @(posedge clock);
    chk(cpu_clk_en, 1'b0);
    irq_mask_flag <= 16'h0000;
    wake;
    chk({vec, n <= 4}, 2'b11);
    irq_accept_enable <= 1'b0;
    sleep(0, 3);
    raise(16'h0002);
    wake;
    chk({vec, n <= 5}, 2'b01);
    raise(16'h0000);
    sleep(0, 3);
    nmi_req <= 1'b1;
    wake;
    chk({vec, n <= 4}, 2'b11);
    irq_accept_enable <= 1'b1;
    raise(16'h0004);
    sleep(0, 0);
    wake;
    chk({vec, n <= 3}, 2'b11);
    done;
    for (i = 0; i < 3; i++) begin
      cfg = $urandom;
      ie = $urandom;
      wr(`SHS_ADDR_PERIPH, {4'h0, cfg});
      sleep(0, 3);
      chk({t16_run, ser0_run, ser1_run}, exp_halt(cfg));
      nmi_req <= 1'b1;
      wake;
      irq_accept_enable <= ie;
      irq_mask_flag <= 16'h0008;
      sleep(1, 3);
      chk({t8a_run, t8b_run, t8c_run, wt_run, disp_run, rc_run, ser0_run,
        ser1_run, t16_run}, exp_stop(cfg));
      raise(16'h0008);
      repeat (10) @(posedge clock);
      chk(main_osc_en, 1'b0);
      irq_mask_flag <= 16'h0000;
      wake;
      chk(n >= `SHS_CNT_12 && n <= `SHS_CNT_12 + 6, 1);
      chk(vec, ie);
      raise(16'h0000);
      done;
    end
    irq_accept_enable <= 1'b1;
    wr(`SHS_ADDR_SETTLE, 16'h0002);
    raise(16'h0010);
    sleep(1, 3);
    chk({main_osc_en, cpu_clk_en}, 2'b10);
    wake;
    chk(n > `SHS_CNT_15 - 8 && n <= `SHS_CNT_15 + 2, 1);
    sleep(0, 3);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk(cpu_clk_en, 1'b1);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(`SHS_ADDR_STATUS);
    chk(rv, `SHS_ST_RUN);
    done;
    results;
  end
endmodule
